// ### logic/asr_count.v
// Down counter used to time pin phases
`timescale 1ns/1ps
`default_nettype none
module asr_count #(
	parameter W = 4
) (
	input wire i_clk, // System clock
	input wire i_arst_n, // Async reset, active low
	input wire i_load, // Load start value
	input wire [W-1:0] i_value, // Start value
	output wire o_done // Count reached zero
);
	reg [W-1:0] cnt_reg;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= {W{1'b0}};
		end else if (i_load) begin
			cnt_reg <= i_value;
		end else if (cnt_reg != {W{1'b0}}) begin
			cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign o_done = (cnt_reg == {W{1'b0}});
endmodule // asr_count
`default_nettype wire

// ### logic/asr_host.v
// Host controller driving an asynchronous 256K x 16 static memory
// Behaviour
// RQ1 - Memory holds 262144 words; 18-bit word address selects each access.
// RQ2 - Write strobe low means write, high means read.
// RQ3 - Chip select high puts memory in standby, data bus floats.
// RQ4 - Low lane enable governs low byte, high lane enable governs high byte.
// RQ5 - Lane enables active low; both high means no byte moves.
// RQ6 - Read: select and drive enable low, strobe high; enabled lanes drive.
// RQ7 - Write: select and strobe low; only enabled lanes are stored.
// RQ8 - Select low, drive enable and strobe high: outputs float.
// RQ9 - Read data valid 12 ns after address/select, 6 ns after drive enable.
// RQ10 - Memory holds old data 3 ns after address changes.
// RQ11 - Lane data valid 7 ns after lane enable falls; floats 7 ns after.
// RQ12 - Outputs float 6 ns after select rises; standby within 12 ns.
// RQ13 - Host spaces accesses at least one 12 ns cycle apart.
// RQ14 - Host keeps address and select valid 8 ns before write end.
// RQ15 - Address may change at write end and apply at write start.
// RQ16 - Host holds strobe low 8 ns, 9 ns with drive enable low.
// RQ17 - Write data set up 6 ns before end; lane enable low 8 ns.
// RQ18 - Memory floats data 5 ns after strobe falls; redrives 3 ns after rise.
// RQ19 - Write spans overlap of select, strobe and lane enable.
// RQ20 - Memory has no reset; contents undefined until written.
// RQ21 - Host never drives data bus while memory drives a read.
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.vh"
module asr_host #(
	parameter AW = `ASR_ADDR_W,
	parameter DW = `ASR_DATA_W
) (
	input wire i_clk, // 50 MHz system clock
	input wire i_arst_n, // Async reset, active low
	input wire i_req, // Request pulse, taken when o_ready high
	input wire i_we, // 1 write, 0 read
	input wire [AW-1:0] i_addr, // Word address
	input wire [1:0] i_lane_en, // Bit0 low byte, bit1 high byte, active high
	input wire [DW-1:0] i_wdata, // Write data
	output reg o_ready, // Idle, may take request
	output reg o_rvalid, // Read data valid pulse
	output reg [DW-1:0] o_rdata, // Read data
	output reg o_wdone, // Write finished pulse
	output reg [AW-1:0] o_word_addr, // Memory address pins
	output reg o_chip_sel_n, // Chip select, active low
	output reg o_drive_en_n, // Output enable, active low
	output reg o_write_strobe_n, // Write strobe, active low
	output reg o_low_lane_sel_n, // Low lane enable
	output reg o_high_lane_sel_n, // High lane enable
	output reg [DW-1:0] o_data_bus, // Data bus out
	output reg o_data_bus_oe, // High while host drives data bus
	input wire [DW-1:0] i_data_bus // Data bus in
);
	localparam CW = 4;
	// Counts worked out as integers, then cut to the counter width on purpose
	localparam integer READ_WAIT_I = `ASR_READ_WAIT_CYC;
	localparam integer WRITE_PULSE_I = `ASR_WRITE_PULSE_CYC;
	localparam integer FLOAT_WAIT_I = `ASR_FLOAT_WAIT_CYC;
	localparam integer GAP_I = `ASR_CYCLE_GAP_CYC;
	localparam [CW-1:0] READ_WAIT = READ_WAIT_I[CW-1:0];
	localparam [CW-1:0] WRITE_PULSE = WRITE_PULSE_I[CW-1:0];
	localparam [CW-1:0] FLOAT_WAIT = FLOAT_WAIT_I[CW-1:0];
	localparam [CW-1:0] GAP = GAP_I[CW-1:0];
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_RD = 6'h02;
	localparam [5:0] S_RSAMP = 6'h04;
	localparam [5:0] S_WSET = 6'h08;
	localparam [5:0] S_WPULSE = 6'h10;
	localparam [5:0] S_GAP = 6'h20;

	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg load;
	reg [CW-1:0] load_val;
	wire done;
	// Two-flop sync of the memory's data pins
	reg [DW-1:0] din_s1_reg;
	reg [DW-1:0] din_s2_reg;

	asr_count #(.W(CW)) u_cnt (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_load(load),
		.i_value(load_val),
		.o_done(done)
	);

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			din_s1_reg <= {DW{1'b0}};
			din_s2_reg <= {DW{1'b0}};
		end else begin
			din_s1_reg <= i_data_bus;
			din_s2_reg <= din_s1_reg;
		end
	end

	always @* begin
		state_next = state_reg;
		load = 1'b0;
		load_val = {CW{1'b0}};
		case (state_reg)
			S_IDLE: begin
				if (i_req) begin
					load = 1'b1;
					if (i_we) begin
						// Two cycles with bus released before the strobe
						state_next = S_WSET; // RQ21
						load_val = FLOAT_WAIT;
					end else begin
						state_next = S_RD;
						load_val = READ_WAIT; // RQ9
					end
				end
			end
			S_RD: begin
				// Three extra cycles let the synchroniser see settled data
				if (done) begin
					state_next = S_RSAMP;
					load = 1'b1;
					load_val = 4'h2;
				end
			end
			S_RSAMP: begin
				if (done) begin
					state_next = S_GAP;
					load = 1'b1;
					load_val = GAP; // RQ13
				end
			end
			S_WSET: begin
				if (done) begin
					state_next = S_WPULSE;
					load = 1'b1;
					load_val = WRITE_PULSE; // RQ16
				end
			end
			S_WPULSE: begin
				if (done) begin
					state_next = S_GAP;
					load = 1'b1;
					load_val = GAP; // RQ13
				end
			end
			S_GAP: begin
				if (done) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= S_IDLE;
			o_ready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= {DW{1'b0}};
			o_wdone <= 1'b0;
			o_word_addr <= {AW{1'b0}};
			o_chip_sel_n <= 1'b1;
			o_drive_en_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_low_lane_sel_n <= 1'b1;
			o_high_lane_sel_n <= 1'b1;
			o_data_bus <= {DW{1'b0}};
			o_data_bus_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			o_rvalid <= 1'b0;
			o_wdone <= 1'b0;
			o_ready <= (state_next == S_IDLE);
			if (state_reg == S_IDLE && i_req) begin
				// Address and lanes set up before strobe or read
				o_word_addr <= i_addr; // RQ1
				o_chip_sel_n <= 1'b0;
				o_low_lane_sel_n <= ~i_lane_en[0]; // RQ4
				o_high_lane_sel_n <= ~i_lane_en[1]; // RQ5
				o_write_strobe_n <= 1'b1;
				if (i_we) begin
					o_drive_en_n <= 1'b1; // RQ21
					o_data_bus <= i_wdata;
				end else begin
					o_drive_en_n <= 1'b0; // RQ6
					o_data_bus_oe <= 1'b0;
				end
			end
			if (state_reg == S_WSET && done) begin
				o_write_strobe_n <= 1'b0; // RQ2
				o_data_bus_oe <= 1'b1; // RQ17
			end
			if (state_reg == S_WPULSE && done) begin
				// Strobe rise ends write; address, select, data held 0 hold
				o_write_strobe_n <= 1'b1; // RQ19
				o_chip_sel_n <= 1'b1; // RQ14
				o_low_lane_sel_n <= 1'b1;
				o_high_lane_sel_n <= 1'b1;
				o_data_bus_oe <= 1'b0; // RQ15
				o_wdone <= 1'b1;
			end
			if (state_reg == S_RSAMP && done) begin
				// Disabled lane reads as zero, it floats at the memory
				o_rdata <= {o_high_lane_sel_n ? {`ASR_LANE_W{1'b0}} : din_s2_reg[DW-1:`ASR_LANE_W],
					o_low_lane_sel_n ? {`ASR_LANE_W{1'b0}} : din_s2_reg[`ASR_LANE_W-1:0]};
				o_rvalid <= 1'b1;
				o_chip_sel_n <= 1'b1; // RQ3
				o_drive_en_n <= 1'b1; // RQ8
				o_low_lane_sel_n <= 1'b1;
				o_high_lane_sel_n <= 1'b1;
			end
		end
	end
endmodule // asr_host
`default_nettype wire

// ### logic/asr_map.vh
// Timing constants and field layout for the static memory host controller
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
`define ASR_CLK_PS 20000
`define ASR_ADDR_W 18
`define ASR_DATA_W 16
`define ASR_LANE_W 8
// Times in picoseconds, figures as printed in ns
`define ASR_READ_CYCLE_MIN_PS 12000
`define ASR_ADDR_TO_DATA_DELAY_PS 12000
`define ASR_DRIVE_TO_DATA_DELAY_PS 6000
`define ASR_LANE_TO_DATA_DELAY_PS 7000
`define ASR_WRITE_CYCLE_MIN_PS 12000
`define ASR_ADDR_BEFORE_WRITE_END_PS 8000
`define ASR_STROBE_WIDTH_DRIVE_OFF_PS 8000
`define ASR_WDATA_SETUP_PS 6000
`define ASR_STROBE_FLOAT_DELAY_PS 5000
`define ASR_LANE_FLOAT_DELAY_PS 7000
`define ASR_DESELECT_FLOAT_DELAY_PS 6000
// Least times round up, at least one cycle
`define ASR_CYC_UP(ps) ((((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS) < 1 ? 1 : \
	(((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS))
`define ASR_READ_WAIT_CYC `ASR_CYC_UP(`ASR_ADDR_TO_DATA_DELAY_PS)
`define ASR_WRITE_PULSE_CYC `ASR_CYC_UP(`ASR_STROBE_WIDTH_DRIVE_OFF_PS)
`define ASR_FLOAT_WAIT_CYC `ASR_CYC_UP(`ASR_DESELECT_FLOAT_DELAY_PS)
`define ASR_CYCLE_GAP_CYC `ASR_CYC_UP(`ASR_WRITE_CYCLE_MIN_PS)
`endif

// ### verif/asr_host_asserts.sv
// Pin-level assertions for the memory host controller
`timescale 1ns/1ps
`default_nettype none
module asr_host_asserts (
	input wire logic i_clk, // Clock
	input wire logic i_arst_n, // Reset
	input wire logic i_req, // Request
	input wire logic i_we, // Write
	input wire logic [17:0] i_addr, // Address
	input wire logic [1:0] i_lane_en, // Lanes
	input wire logic [15:0] i_wdata, // Data
	input wire logic o_ready, // Idle
	input wire logic o_rvalid, // Read done
	input wire logic o_wdone, // Write done
	input wire logic [17:0] o_word_addr, // Pins
	input wire logic o_chip_sel_n, // Select
	input wire logic o_drive_en_n, // Drive enable
	input wire logic o_write_strobe_n, // Strobe
	input wire logic o_low_lane_sel_n, // Low lane
	input wire logic o_high_lane_sel_n, // High lane
	input wire logic [15:0] o_data_bus, // Data out
	input wire logic o_data_bus_oe // Host drives
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	wire [1:0] ln_n = {o_high_lane_sel_n, o_low_lane_sel_n};
	sequence s_rd; o_ready && i_req && !i_we; endsequence
	sequence s_wr; o_ready && i_req && i_we; endsequence
	a_read_pins: assert property (s_rd |=> !o_chip_sel_n && !o_drive_en_n && o_write_strobe_n
		&& ln_n == ~$past(i_lane_en) && o_word_addr == $past(i_addr)) else $error("read pins wrong");
	a_read_answer: assert property (s_rd |-> ##6 o_rvalid) else $error("read answer late");
	a_write_answer: assert property (s_wr |-> ##5 o_wdone) else $error("write answer late");
	a_write_pins: assert property ($fell(o_write_strobe_n) |-> !o_chip_sel_n && o_drive_en_n
		&& o_data_bus_oe && ln_n == ~$past(i_lane_en, 3) && o_data_bus == $past(i_wdata, 3)
		&& o_word_addr == $past(i_addr, 3)) else $error("write pins wrong");
	a_write_end: assert property ($fell(o_write_strobe_n) |=> !o_write_strobe_n && o_data_bus_oe
		##1 o_write_strobe_n && o_chip_sel_n && ln_n == 2'h3 && !o_data_bus_oe) else $error("write end wrong");
	a_bus_drive: assert property (o_data_bus_oe |-> !o_write_strobe_n && !o_chip_sel_n)
		else $error("bus driven outside write");
	a_read_release: assert property (o_rvalid |-> o_chip_sel_n && o_drive_en_n)
		else $error("select held after read");
	a_answer_gap: assert property (o_rvalid || o_wdone |=> !o_ready ##1 o_ready)
		else $error("gap wrong");
endmodule // asr_host_asserts
bind asr_host asr_host_asserts i_asr_host_asserts (.i_clk, .i_arst_n, .i_req, .i_we, .i_addr, .i_lane_en,
	.i_wdata, .o_ready, .o_rvalid, .o_wdone, .o_word_addr, .o_chip_sel_n, .o_drive_en_n, .o_write_strobe_n,
	.o_low_lane_sel_n, .o_high_lane_sel_n, .o_data_bus, .o_data_bus_oe);
`default_nettype wire

// ### verif/asr_sram_model.sv
// Behavioural static memory facing the host pins
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model #(
	parameter int DLY = 0
) (
	input wire logic [17:0] i_a, // Address
	input wire logic i_cs_n, // Select
	input wire logic i_oe_n, // Drive enable
	input wire logic i_we_n, // Strobe
	input wire logic [1:0] i_ln_n, // Lanes, bit0 low
	input wire logic [15:0] i_hd, // Host data
	input wire logic i_hoe, // Host drives
	output wire logic [15:0] o_bus // Wire level
);
	logic [15:0] mem [0:262143];
	logic [15:0] v;
	// Explicit list: a star list would watch every word of the array
	always @(i_a or i_cs_n or i_oe_n or i_we_n or i_ln_n or i_hd or i_hoe) begin
		for (int i = 0; i < 2; i++) begin
			// Stores only data the host really drives inside the write overlap
			if (!i_cs_n && !i_we_n && !i_ln_n[i] && i_hoe) mem[i_a][i*8+:8] = i_hd[i*8+:8];
			// Floating lanes show the inverse so a stale sample cannot pass
			v[i*8+:8] = i_hoe ? i_hd[i*8+:8] : (!i_cs_n && !i_oe_n && i_we_n && !i_ln_n[i])
				? mem[i_a][i*8+:8] : ~mem[i_a][i*8+:8];
		end
	end
	// Inertial delay keeps old data well past the address change
	assign #(DLY) o_bus = v;
endmodule // asr_sram_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk = 0, i_arst_n = 0, i_req = 0, i_we = 0;
	logic [17:0] i_addr = '0;
	logic [1:0] i_lane_en = '0;
	logic [15:0] i_wdata = '0;
	wire o_ready, o_rvalid, o_wdone, o_chip_sel_n, o_drive_en_n, o_write_strobe_n;
	wire o_low_lane_sel_n, o_high_lane_sel_n, o_data_bus_oe;
	wire [15:0] o_rdata, o_data_bus, i_data_bus;
	wire [17:0] o_word_addr;
	int num_errors = 0, n_checks = 0, cyc = 0;
	// Write flag, address, lanes, write data, expected read
	logic [52:0] rows [9] = '{
		{1'h1, 18'h3FFFF, 2'h3, 16'hA5C3, 16'h0}, {1'h1, 18'h3FFFF, 2'h1, 16'h0011, 16'h0},
		{1'h1, 18'h3FFFF, 2'h2, 16'h2200, 16'h0}, {1'h0, 18'h3FFFF, 2'h3, 16'h0, 16'h2211},
		{1'h0, 18'h3FFFF, 2'h1, 16'h0, 16'h0011}, {1'h0, 18'h3FFFF, 2'h2, 16'h0, 16'h2200},
		{1'h1, 18'h00000, 2'h3, 16'hBEEF, 16'h0}, {1'h1, 18'h00000, 2'h0, 16'h1234, 16'h0},
		{1'h0, 18'h00000, 2'h0, 16'h0, 16'h0}};
	asr_host i_asr_host (.i_clk, .i_arst_n, .i_req, .i_we, .i_addr, .i_lane_en, .i_wdata, .o_ready, .o_rvalid,
		.o_rdata, .o_wdone, .o_word_addr, .o_chip_sel_n, .o_drive_en_n, .o_write_strobe_n, .o_low_lane_sel_n,
		.o_high_lane_sel_n, .o_data_bus, .o_data_bus_oe, .i_data_bus);
	asr_sram_model #(.DLY(11)) i_asr_sram_model (.i_a(o_word_addr), .i_cs_n(o_chip_sel_n), .i_oe_n(o_drive_en_n),
		.i_we_n(o_write_strobe_n), .i_ln_n({o_high_lane_sel_n, o_low_lane_sel_n}), .i_hd(o_data_bus),
		.i_hoe(o_data_bus_oe), .o_bus(i_data_bus));
	initial forever #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task op(input logic [52:0] r, input logic hold);
		int n;
		n = 0;
		while (!o_ready && n < 20) begin
			@(posedge i_clk);
			n++;
		end
		{i_we, i_addr, i_lane_en, i_wdata} <= r[52:16];
		i_req <= 1'b1;
		@(posedge i_clk);
		if (hold) begin
			// Controller is busy now, so this must be dropped
			{i_addr, i_wdata} <= {18'h00000, 16'hFFFF};
			@(posedge i_clk);
		end
		i_req <= 1'b0;
		n = 0;
		while (!(o_rvalid || o_wdone) && n < 20) begin
			@(posedge i_clk);
			n++;
		end
		chk(16'(n < 20), 16'h1);
		if (!r[52]) chk(o_rdata, r[15:0]);
	endtask
	task tally_and_finish;
		if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		foreach (rows[k]) op(rows[k], 1'b0);
		chk({11'h0, o_chip_sel_n, o_drive_en_n, o_write_strobe_n, o_low_lane_sel_n, o_high_lane_sel_n}, 16'h1F);
		op({1'h1, 18'h00001, 2'h3, 16'h5A5A, 16'h0}, 1'b1);
		op({1'h0, 18'h00000, 2'h3, 16'h0, 16'hBEEF}, 1'b0);
		op({1'h0, 18'h00001, 2'h3, 16'h0, 16'h5A5A}, 1'b0);
		{i_we, i_req} <= 2'h1;
		repeat (4) @(posedge i_clk);
		{i_arst_n, i_req} <= 2'h0;
		#5;
		chk({7'h0, o_ready, o_chip_sel_n, o_drive_en_n, o_write_strobe_n, o_low_lane_sel_n, o_high_lane_sel_n,
			o_rvalid, o_wdone, o_data_bus_oe}, 16'h01F8);
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		op(rows[3], 1'b0);
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
